// [fifo_ctrl_cfg.svh]
// Constants for the deep dual-port buffer control block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef FIFO_CTRL_CFG_SVH
`define FIFO_CTRL_CFG_SVH

// Storage shape
`define CFG_DATA_W 18
`define CFG_DEPTH 8192
`define CFG_OFFS_W 13

// Default almost-flag offsets picked at full clear
`define CFG_OFFSET_PARALLEL 13'h07f
`define CFG_OFFSET_SERIAL 13'h3ff

// Read edges spent in replay setup, start edge included
`define CFG_REPLAY_EDGES 4'h2

// Pointer value of the first memory location
`define CFG_FIRST_LOC 0

`endif

// [fifo_ctrl_pkg.sv]
// Types shared by the buffer control block.
// Assumes no other package; every use is package-qualified.
package fifo_ctrl_pkg;

    // Timing mode latched at full clear
    typedef enum logic [1:0] {
        MODE_REQ = 2'b01,
        MODE_FALL = 2'b10
    } mode_t;

    // Replay setup sequencer
    typedef enum logic [1:0] {
        RP_IDLE = 2'b01,
        RP_SETUP = 2'b10
    } replay_t;

    // Configuration captured at full clear
    typedef struct packed {
        mode_t mode;
        logic serialLoad;
    } setup_t;

endpackage

// [dual_clock_fifo_ctrl.sv]
// Deep buffer with write and read sides, clears, mode select and replay.
// Assumes every input is synchronous to core_clk; write_clock and read_clock
// are strobes whose rising edges are detected on core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "fifo_ctrl_cfg.svh"

module dual_clock_fifo_ctrl #(
    parameter int DATA_W = `CFG_DATA_W,
    parameter int DEPTH = `CFG_DEPTH,
    parameter int OFFS_W = `CFG_OFFS_W
) (
    input wire logic core_clk, // 100 MHz system clock
    input wire logic rstn, // Power-on reset, active low
    input wire logic full_clear_n, // Full clear, active low
    input wire logic partial_clear_n, // Partial clear, active low
    input wire logic mode_select_serial_in, // Mode at full clear, serial bit after
    input wire logic offset_load_n, // Offset access / default select
    input wire logic serial_enable_n, // Serial offset shift enable
    input wire logic write_clock, // Write strobe, rising edge acts
    input wire logic write_enable_n, // Write enable, active low
    input wire logic [DATA_W-1:0] write_data, // Write word
    input wire logic read_clock, // Read strobe, rising edge acts
    input wire logic read_enable_n, // Read enable, active low
    input wire logic replay_request_n, // Replay request, active low
    output logic [DATA_W-1:0] read_data, // Output data register
    output logic empty_flag_n, // Empty, requested-read mode
    output logic full_flag_n, // Full, requested-read mode
    output logic output_valid_n, // Output valid, fall-through mode
    output logic input_space_n, // Space free, fall-through mode
    output logic almost_empty_flag_n, // Almost empty
    output logic almost_full_flag_n, // Almost full
    output logic half_full_flag_n // Half full
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH);
    localparam logic [AW:0] HALF_V = (AW+1)'(DEPTH / 2);

    // Elaboration check: pointer wrap needs a power-of-two depth
    if (DEPTH < 4 || (1 << AW) != DEPTH || OFFS_W < 10 || DATA_W < OFFS_W) begin : g_bad_param
        $error("dual_clock_fifo_ctrl: unsupported parameter set");
    end

    // Occupancy between two pointers of one extra wrap bit
    function automatic logic [AW:0] occ(input logic [AW:0] wp, input logic [AW:0] rp);
        occ = wp - rp;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Reset release and strobe edges
    logic [1:0] rstSync_q;
    logic rstnInt, wclkPrev_q, rclkPrev_q, writeEdge, readEdge, fullClr, anyClr;
    // Two-stage release, clean on core_clk
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstnInt = rstSync_q[1];

    // Previous strobe levels
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            wclkPrev_q <= 1'b0;
            rclkPrev_q <= 1'b0;
        end else begin
            wclkPrev_q <= write_clock;
            rclkPrev_q <= read_clock;
        end
    end

    // edges per side
    // Each side acts on its own edge; equal strobes just coincide
    assign writeEdge = write_clock & ~wclkPrev_q;
    assign readEdge = read_clock & ~rclkPrev_q;
    // level-acting clears
    // Clears act on core_clk level, not on either strobe
    assign fullClr = ~full_clear_n;
    assign anyClr = fullClr | ~partial_clear_n;

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and offset registers
    fifo_ctrl_pkg::setup_t setup_q;
    logic [OFFS_W-1:0] emptyOff_q, fullOff_q;
    logic armed_q, wrOffSel_q, isFall, clrFall;
    assign isFall = (setup_q.mode == fifo_ctrl_pkg::MODE_FALL);
    // Clear flags follow the pin in full clear, kept mode otherwise
    assign clrFall = fullClr ? mode_select_serial_in : isFall;

    // Latch mode, loading method and defaults; only full clear touches them
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            setup_q <= '{mode: fifo_ctrl_pkg::MODE_REQ, serialLoad: 1'b0};
            armed_q <= 1'b0;
            emptyOff_q <= OFFS_W'(`CFG_OFFSET_PARALLEL);
            fullOff_q <= OFFS_W'(`CFG_OFFSET_PARALLEL);
            wrOffSel_q <= 1'b0;
        end else if (fullClr) begin
            setup_q.mode <= mode_select_serial_in ? fifo_ctrl_pkg::MODE_FALL
                                                  : fifo_ctrl_pkg::MODE_REQ;
            setup_q.serialLoad <= offset_load_n;
            armed_q <= 1'b1;
            wrOffSel_q <= 1'b0;
            if (offset_load_n) begin
                emptyOff_q <= OFFS_W'(`CFG_OFFSET_SERIAL);
                fullOff_q <= OFFS_W'(`CFG_OFFSET_SERIAL);
            end else begin
                emptyOff_q <= OFFS_W'(`CFG_OFFSET_PARALLEL);
                fullOff_q <= OFFS_W'(`CFG_OFFSET_PARALLEL);
            end
        end else if (writeEdge && !offset_load_n && partial_clear_n) begin
            if (setup_q.serialLoad) begin
                // one bit per write edge
                // First bit shifted in ends at the empty offset LSB
                if (!serial_enable_n) begin
                    {fullOff_q, emptyOff_q} <= {mode_select_serial_in, fullOff_q,
                                                emptyOff_q[OFFS_W-1:1]};
                end
            end else if (!write_enable_n) begin
                // parallel load alternates empty then full offset
                if (wrOffSel_q) begin
                    fullOff_q <= write_data[OFFS_W-1:0];
                end else begin
                    emptyOff_q <= write_data[OFFS_W-1:0];
                end
                wrOffSel_q <= ~wrOffSel_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write side
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW:0] wptr_q, rptrW1_q, rptrW2_q, wptrNext, wCnt, rptr_q;
    logic fullInt_q, fullN_q, spaceN_q, almostFullN_q, doWrite, halfSetW;
    // full-width word accepted
    // Memory writes need offset access off and space left
    assign doWrite = writeEdge & ~write_enable_n & offset_load_n & ~fullInt_q & armed_q;
    assign wptrNext = doWrite ? wptr_q + 1'b1 : wptr_q;
    // full at depth
    // Fall-through output register holds the one extra word
    assign wCnt = occ(wptrNext, rptrW2_q);
    assign halfSetW = writeEdge & (wCnt > HALF_V);
    // Storage array, no reset needed
    always_ff @(posedge core_clk) begin
        if (doWrite && !anyClr) begin
            mem[wptr_q[AW-1:0]] <= write_data;
        end
    end

    // Write pointer, read-pointer sync and write-side flags
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            wptr_q <= '0;
            rptrW1_q <= '0;
            rptrW2_q <= '0;
            fullInt_q <= 1'b0;
            fullN_q <= 1'b1;
            spaceN_q <= 1'b1;
            almostFullN_q <= 1'b1;
        end else if (anyClr) begin
            wptr_q <= (AW+1)'(`CFG_FIRST_LOC);
            rptrW1_q <= (AW+1)'(`CFG_FIRST_LOC);
            rptrW2_q <= (AW+1)'(`CFG_FIRST_LOC);
            fullInt_q <= 1'b0;
            almostFullN_q <= 1'b1;
            fullN_q <= 1'b1;
            spaceN_q <= ~clrFall;
        end else if (writeEdge) begin
            // flags move on write edges only
            rptrW1_q <= rptr_q;
            rptrW2_q <= rptrW1_q;
            wptr_q <= wptrNext;
            fullInt_q <= (wCnt == DEPTH_V);
            fullN_q <= isFall | (wCnt != DEPTH_V);
            spaceN_q <= ~isFall | (wCnt == DEPTH_V);
            almostFullN_q <= (int'(wCnt) + int'(fullOff_q) < DEPTH);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read side
    fifo_ctrl_pkg::replay_t replay_q;
    logic [3:0] replayCnt_q;
    logic [AW:0] wptrR1_q, wptrR2_q, rptrNext, rCnt;
    logic [DATA_W-1:0] readData_q;
    logic outValid_q, emptyN_q, validN_q, almostEmptyN_q, rdOffSel_q, avail, offRead;
    logic loadWord, dropValid, replayDone, halfClrR;
    assign avail = (wptrR2_q != rptr_q);
    // Start edge leaves the count at zero, so the last edge sees edges minus two
    assign replayDone = (replay_q == fifo_ctrl_pkg::RP_SETUP)
                        && (replayCnt_q == `CFG_REPLAY_EDGES - 4'h2);
    assign offRead = readEdge && replay_q == fifo_ctrl_pkg::RP_IDLE && replay_request_n
                     && !offset_load_n && !read_enable_n;

    // Decide memory fetches on a read edge
    always_comb begin
        loadWord = 1'b0;
        dropValid = 1'b0;
        if (readEdge && replay_request_n && !offRead) begin
            if (replayDone) begin
                // fall-through shows first word at setup end
                loadWord = isFall && avail;
            end else if (replay_q == fifo_ctrl_pkg::RP_IDLE && !isFall) begin
                loadWord = !read_enable_n && avail;
            end else if (replay_q == fifo_ctrl_pkg::RP_IDLE) begin
                loadWord = (!outValid_q || !read_enable_n) && avail;
                dropValid = outValid_q && !read_enable_n && !avail;
            end
        end
    end

    assign rptrNext = loadWord ? rptr_q + 1'b1 : rptr_q;
    assign rCnt = occ(wptrR1_q, rptrNext);
    // Read side may only release half-full
    assign halfClrR = readEdge & (rCnt <= HALF_V);

    // Read pointer, write-pointer sync, output register and read flags
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            replay_q <= fifo_ctrl_pkg::RP_IDLE;
            replayCnt_q <= 4'h0;
            rptr_q <= '0;
            wptrR1_q <= '0;
            wptrR2_q <= '0;
            readData_q <= '0;
            outValid_q <= 1'b0;
            emptyN_q <= 1'b0;
            validN_q <= 1'b1;
            almostEmptyN_q <= 1'b0;
            rdOffSel_q <= 1'b0;
        end else if (anyClr) begin
            replay_q <= fifo_ctrl_pkg::RP_IDLE;
            replayCnt_q <= 4'h0;
            rptr_q <= (AW+1)'(`CFG_FIRST_LOC);
            wptrR1_q <= (AW+1)'(`CFG_FIRST_LOC);
            wptrR2_q <= (AW+1)'(`CFG_FIRST_LOC);
            readData_q <= '0;
            outValid_q <= 1'b0;
            almostEmptyN_q <= 1'b0;
            emptyN_q <= clrFall;
            validN_q <= 1'b1;
            if (fullClr) begin
                rdOffSel_q <= 1'b0;
            end
        end else if (readEdge) begin
            wptrR1_q <= wptr_q;
            wptrR2_q <= wptrR1_q;
            almostEmptyN_q <= (int'(rCnt) > int'(emptyOff_q));
            if (!replay_request_n) begin
                // rewind read pointer
                // Fetch and readback both need replay_request_n high, so no fetch competes here
                replay_q <= fifo_ctrl_pkg::RP_SETUP;
                replayCnt_q <= 4'h0;
                rptr_q <= (AW+1)'(`CFG_FIRST_LOC);
                outValid_q <= 1'b0;
                emptyN_q <= isFall;
                validN_q <= 1'b1;
            end else begin
                if (replay_q == fifo_ctrl_pkg::RP_SETUP) begin
                    replayCnt_q <= replayCnt_q + 4'h1;
                    if (replayDone) begin
                        replay_q <= fifo_ctrl_pkg::RP_IDLE;
                    end
                end
                rptr_q <= rptrNext;
                if (offRead) begin
                    // Readback overwrites the output word
                    readData_q <= rdOffSel_q ? DATA_W'(fullOff_q) : DATA_W'(emptyOff_q);
                    rdOffSel_q <= ~rdOffSel_q;
                end else if (loadWord) begin
                    readData_q <= mem[rptr_q[AW-1:0]];
                end
                if (loadWord) begin
                    outValid_q <= 1'b1;
                end else if (dropValid) begin
                    outValid_q <= 1'b0;
                end
                if (replay_q == fifo_ctrl_pkg::RP_IDLE || replayDone) begin
                    emptyN_q <= isFall | (wptrR1_q != rptrNext);
                    validN_q <= ~isFall | ~(loadWord | (outValid_q & ~dropValid));
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Half-full flag shared by both sides
    logic halfN_q;
    // Write-side set wins over read-side release
    always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
            halfN_q <= 1'b1;
        end else if (anyClr) begin
            halfN_q <= 1'b1;
        end else if (halfSetW) begin
            halfN_q <= 1'b0;
        end else if (halfClrR) begin
            halfN_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    assign read_data = readData_q;
    assign empty_flag_n = emptyN_q;
    assign full_flag_n = fullN_q;
    assign output_valid_n = validN_q;
    assign input_space_n = spaceN_q;
    assign almost_empty_flag_n = almostEmptyN_q;
    assign almost_full_flag_n = almostFullN_q;
    assign half_full_flag_n = halfN_q;

endmodule // dual_clock_fifo_ctrl
`default_nettype wire

// [fifo_ctrl_monitor.sv]
// Checker for clear values, mode flags, replay marks and flag update sources.
// Assumes it is bound into dual_clock_fifo_ctrl; strobes are sampled on core_clk.
`timescale 1ns/10ps
`default_nettype none

module fifo_ctrl_monitor #(
    parameter int DATA_W = 18
) (
    input wire logic core_clk, // clock
    input wire logic rstn, // reset
    input wire logic full_clear_n, // full clear
    input wire logic partial_clear_n, // partial clear
    input wire logic mode_select_serial_in, // mode pin
    input wire logic write_clock, // write strobe
    input wire logic read_clock, // read strobe
    input wire logic replay_request_n, // replay
    input wire logic [DATA_W-1:0] read_data, // output word
    input wire logic empty_flag_n, // empty
    input wire logic full_flag_n, // full
    input wire logic output_valid_n, // valid
    input wire logic input_space_n, // space
    input wire logic almost_empty_flag_n, // almost empty
    input wire logic almost_full_flag_n, // almost full
    input wire logic half_full_flag_n // half full
);
    logic wrPrev_q;
    logic rdPrev_q;
    logic modeFall_q;
    logic writeEdge;
    logic readEdge;

    // Strobe history, same edge rule as the block
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrPrev_q <= 1'b0;
            rdPrev_q <= 1'b0;
        end else begin
            wrPrev_q <= write_clock;
            rdPrev_q <= read_clock;
        end
    end

    // Mode seen at full clear; requested-read before any
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            modeFall_q <= 1'b0;
        end else if (!full_clear_n) begin
            modeFall_q <= mode_select_serial_in;
        end
    end

    assign writeEdge = write_clock && !wrPrev_q;
    assign readEdge = read_clock && !rdPrev_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////
    a_full_clear_out: assert property (!full_clear_n |=>
        read_data == '0 && !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
        else $error("full clear outputs wrong");
    a_clear_req_mode: assert property (!full_clear_n && !mode_select_serial_in |=>
        !empty_flag_n && full_flag_n && output_valid_n && input_space_n)
        else $error("requested-read clear flags wrong");
    a_clear_fall_mode: assert property (!full_clear_n && mode_select_serial_in |=>
        empty_flag_n && full_flag_n && output_valid_n && !input_space_n)
        else $error("fall-through clear flags wrong");
    a_part_clear_out: assert property (!partial_clear_n |=>
        read_data == '0 && !almost_empty_flag_n && almost_full_flag_n && half_full_flag_n)
        else $error("partial clear outputs wrong");
    a_part_clear_mode: assert property (!partial_clear_n && full_clear_n |=>
        (modeFall_q ? (empty_flag_n && full_flag_n && output_valid_n && !input_space_n)
        : (!empty_flag_n && full_flag_n && output_valid_n && input_space_n)))
        else $error("partial clear lost mode");
    a_data_read_only: assert property ($changed(read_data) |->
        $past(readEdge) || !$past(full_clear_n) || !$past(partial_clear_n))
        else $error("read data moved off read edge");
    a_wflags_frozen: assert property (
        $changed({full_flag_n, input_space_n, almost_full_flag_n}) |->
        $past(writeEdge) || !$past(full_clear_n) || !$past(partial_clear_n))
        else $error("write flags moved off write edge");
    a_rflags_frozen: assert property (
        $changed({empty_flag_n, output_valid_n, almost_empty_flag_n}) |->
        $past(readEdge) || !$past(full_clear_n) || !$past(partial_clear_n))
        else $error("read flags moved off read edge");
    a_half_set_write: assert property ($fell(half_full_flag_n) |-> $past(writeEdge))
        else $error("half full set off a write edge");
    a_replay_mark: assert property (
        readEdge && !replay_request_n && full_clear_n && partial_clear_n |=>
        (modeFall_q ? output_valid_n : !empty_flag_n))
        else $error("replay start not marked");
endmodule // fifo_ctrl_monitor

bind dual_clock_fifo_ctrl fifo_ctrl_monitor #(.DATA_W(DATA_W)) i_monitor (
    .core_clk(core_clk), .rstn(rstn), .full_clear_n(full_clear_n),
    .partial_clear_n(partial_clear_n), .mode_select_serial_in(mode_select_serial_in),
    .write_clock(write_clock), .read_clock(read_clock), .replay_request_n(replay_request_n),
    .read_data(read_data), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .output_valid_n(output_valid_n), .input_space_n(input_space_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
    .half_full_flag_n(half_full_flag_n)
);
`default_nettype wire

// [fifo_stream_partner.sv]
// Writer and reader model for the buffer's strobe, enable and data pins.
// Assumes core_clk is the block clock; one strobe edge spans two cycles.
`timescale 1ns/10ps
`default_nettype none

module fifo_stream_partner #(
    parameter int DW = 18
) (
    input wire logic core_clk, // clock
    output logic write_clock, // write strobe
    output logic write_enable_n, // write enable
    output logic [DW-1:0] write_data, // write word
    output logic read_clock, // read strobe
    output logic read_enable_n, // read enable
    output logic replay_request_n // replay
);
    // Idle levels from time zero
    initial begin
        write_clock = 1'b0;
        write_enable_n = 1'b1;
        write_data = '0;
        read_clock = 1'b0;
        read_enable_n = 1'b1;
        replay_request_n = 1'b1;
    end

    // One write edge; data inverted after so a stale word never looks held
    task automatic wr(input logic [DW-1:0] d, input logic en_n);
        @(posedge core_clk);
        write_clock <= 1'b1;
        write_enable_n <= en_n;
        write_data <= d;
        @(posedge core_clk);
        write_clock <= 1'b0;
        write_enable_n <= 1'b1;
        write_data <= ~d;
        #1;
    endtask

    // One read edge, optionally a replay request
    task automatic rd(input logic en_n, input logic rt_n);
        @(posedge core_clk);
        read_clock <= 1'b1;
        read_enable_n <= en_n | ~rt_n;
        replay_request_n <= rt_n;
        @(posedge core_clk);
        read_clock <= 1'b0;
        read_enable_n <= 1'b1;
        replay_request_n <= 1'b1;
        #1;
    endtask
endmodule // fifo_stream_partner
`default_nettype wire

// [dual_clock_fifo_ctrl_tb_top.sv]
// Bench for clears, modes, default offsets, replay and full counts.
// Assumes the partner drives strobes; depth is shrunk to 16 words.
`timescale 1ns/10ps
`default_nettype none
`include "fifo_ctrl_cfg.svh"

module dual_clock_fifo_ctrl_tb_top;
    localparam int DW = `CFG_DATA_W;
    localparam int DEPTH = 16;
    localparam logic [DW-1:0] WORDS [3] = '{18'h3ffff, 18'h00001, 18'h2a5c3};
    localparam logic [25:0] SER = {13'h1c3, 13'h0a5};
    logic core_clk, rstn, full_clear_n, partial_clear_n, mode_select_serial_in;
    logic offset_load_n, serial_enable_n, write_clock, write_enable_n, read_clock;
    logic read_enable_n, replay_request_n, empty_flag_n, full_flag_n, output_valid_n;
    logic input_space_n, almost_empty_flag_n, almost_full_flag_n, half_full_flag_n;
    logic [DW-1:0] write_data, read_data;
    logic [6:0] flags;
    int n_errors, checks_done;

    assign flags = {empty_flag_n, full_flag_n, output_valid_n, input_space_n,
        almost_empty_flag_n, almost_full_flag_n, half_full_flag_n};

    dual_clock_fifo_ctrl #(.DEPTH(DEPTH)) i_dut (
        .core_clk(core_clk), .rstn(rstn), .full_clear_n(full_clear_n),
        .partial_clear_n(partial_clear_n), .mode_select_serial_in(mode_select_serial_in),
        .offset_load_n(offset_load_n), .serial_enable_n(serial_enable_n),
        .write_clock(write_clock), .write_enable_n(write_enable_n), .write_data(write_data),
        .read_clock(read_clock), .read_enable_n(read_enable_n),
        .replay_request_n(replay_request_n), .read_data(read_data),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .output_valid_n(output_valid_n), .input_space_n(input_space_n),
        .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n),
        .half_full_flag_n(half_full_flag_n));

    fifo_stream_partner #(.DW(DW)) i_partner (
        .core_clk(core_clk), .write_clock(write_clock), .write_enable_n(write_enable_n),
        .write_data(write_data), .read_clock(read_clock), .read_enable_n(read_enable_n),
        .replay_request_n(replay_request_n));

    ////////////////////////////////////////
    task automatic chk_data(input logic [DW-1:0] exp);
        checks_done++;
        if (read_data !== exp) begin
            n_errors++;
            $display("unexpected at %0t: read data %h want %h", $time, read_data, exp);
        end
    endtask

    // Masked: some flags vary at this depth
    task automatic chk_flags(input logic [6:0] exp, input logic [6:0] mask);
        checks_done++;
        if ((flags & mask) !== (exp & mask)) begin
            n_errors++;
            $display("unexpected at %0t: flags %b want %b", $time, flags & mask, exp & mask);
        end
    endtask

    task automatic clr(input logic full, input logic ms, input logic ld);
        @(posedge core_clk);
        mode_select_serial_in <= ms;
        offset_load_n <= ld;
        full_clear_n <= ~full;
        partial_clear_n <= full;
        repeat (2) @(posedge core_clk);
        full_clear_n <= 1'b1;
        partial_clear_n <= 1'b1;
        mode_select_serial_in <= 1'b0;
        offset_load_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic readback(input logic [DW-1:0] e, input logic [DW-1:0] f);
        @(posedge core_clk);
        offset_load_n <= 1'b0;
        i_partner.rd(1'b0, 1'b1);
        chk_data(e);
        i_partner.rd(1'b0, 1'b1);
        chk_data(f);
        @(posedge core_clk);
        offset_load_n <= 1'b1;
    endtask

    ////////////////////////////////////////
    task automatic test_req();
        clr(1'b1, 1'b0, 1'b0);
        chk_flags(7'h3b, 7'h7f);
        chk_data('0);
        readback(18'h0007f, 18'h0007f);
        for (int i = 0; i < 3; i++)
            i_partner.wr(WORDS[i], 1'b0);
        i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h00, 7'h40);
        i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h40, 7'h40);
        chk_data(18'h0007f);
        for (int i = 0; i < 3; i++) begin
            i_partner.rd(1'b0, 1'b1);
            chk_data(WORDS[i]);
        end
        i_partner.rd(1'b1, 1'b0);
        chk_flags(7'h00, 7'h40);
        i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h40, 7'h40);
        chk_data(WORDS[2]);
        i_partner.rd(1'b0, 1'b1);
        chk_data(WORDS[0]);
        $display("test requested-read done");
    endtask

    task automatic test_fill();
        clr(1'b0, 1'b0, 1'b1);
        chk_flags(7'h3b, 7'h7f);
        chk_data('0);
        for (int i = 0; i < DEPTH; i++) begin
            chk_flags(7'h20, 7'h20);
            i_partner.wr(DW'(i + 1), 1'b0);
        end
        chk_flags(7'h00, 7'h21);
        i_partner.wr(18'h15555, 1'b0);
        repeat (2) i_partner.rd(1'b1, 1'b1);
        for (int i = 0; i < DEPTH; i++) begin
            i_partner.rd(1'b0, 1'b1);
            chk_data(DW'(i + 1));
        end
        i_partner.rd(1'b0, 1'b1);
        chk_data(DW'(DEPTH));
        $display("test fill done");
    endtask

    task automatic test_fall();
        clr(1'b1, 1'b1, 1'b1);
        chk_flags(7'h73, 7'h7f);
        chk_data('0);
        readback(18'h003ff, 18'h003ff);
        i_partner.wr(WORDS[2], 1'b0);
        i_partner.wr(WORDS[0], 1'b0);
        repeat (2) i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h10, 7'h10);
        i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h00, 7'h10);
        chk_data(WORDS[2]);
        i_partner.rd(1'b1, 1'b1);
        chk_data(WORDS[2]);
        i_partner.rd(1'b0, 1'b1);
        chk_data(WORDS[0]);
        i_partner.rd(1'b1, 1'b0);
        chk_flags(7'h10, 7'h10);
        i_partner.rd(1'b1, 1'b1);
        chk_flags(7'h00, 7'h10);
        chk_data(WORDS[2]);
        clr(1'b0, 1'b0, 1'b1);
        chk_flags(7'h73, 7'h7f);
        i_partner.wr(WORDS[1], 1'b0);
        repeat (3) i_partner.rd(1'b1, 1'b1);
        for (int i = 1; i <= DEPTH; i++) begin
            chk_flags(7'h00, 7'h08);
            i_partner.wr(DW'(i), 1'b0);
        end
        chk_flags(7'h08, 7'h08);
        $display("test fall-through done");
    endtask

    task automatic test_serial();
        @(posedge core_clk);
        offset_load_n <= 1'b0;
        serial_enable_n <= 1'b0;
        for (int i = 0; i < 26; i++) begin
            @(posedge core_clk);
            mode_select_serial_in <= SER[i];
            i_partner.wr('0, 1'b1);
        end
        @(posedge core_clk);
        serial_enable_n <= 1'b1;
        i_partner.wr(18'h00055, 1'b0);
        clr(1'b0, 1'b0, 1'b1);
        readback(18'h000a5, 18'h001c3);
        $display("test serial offsets done");
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Clear before any write, so the block is armed
    initial begin
        rstn = 1'b0;
        full_clear_n = 1'b1;
        partial_clear_n = 1'b1;
        mode_select_serial_in = 1'b0;
        offset_load_n = 1'b1;
        serial_enable_n = 1'b1;
        n_errors = 0;
        checks_done = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        test_req();
        test_fill();
        test_fall();
        test_serial();
        give_verdict();
    end

    // Hang guard, far past the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge core_clk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule // dual_clock_fifo_ctrl_tb_top
`default_nettype wire
